// [rtl/busy_pin_drive.sv]
// Drive of a busy line: low while owned, high one cycle, then released
module busy_pin_drive
    import sysbus_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Ownership level for the next cycle
    input wire logic own,
    // Pin
    output logic pin_n,
    output logic pin_oe
);
    busy_s st_reg;      // Registered state
    busy_s st_next;     // Next state

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: the high cycle avoids a slow pull-up rise after release
    always_comb begin
        st_next = st_reg;
        st_next.own_q = own;
        if (own) begin
            st_next.pin_n = 1'b0;
            st_next.oe = 1'b1;
        end else if (st_reg.own_q) begin
            st_next.pin_n = 1'b1;
            st_next.oe = 1'b1;
        end else begin
            st_next.pin_n = 1'b1;
            st_next.oe = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= BUSY_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign pin_n = st_reg.pin_n;
    assign pin_oe = st_reg.oe;
endmodule

// [rtl/lane_parity.sv]
// Odd parity per byte lane of a data word
module lane_parity #(
    parameter int DATA_W = 32,
    parameter int LANE_W = 8
) (
    // Data word
    input wire logic [DATA_W-1:0] data,
    // Parity bits that make each lane odd
    output logic [DATA_W/LANE_W-1:0] parity
);
    ////////////////////////////////////////////////////////////////////////////////
    // One odd parity bit per lane
    for (genvar i = 0; i < DATA_W / LANE_W; i++) begin : g_lane
        assign parity[i] = ~^data[i*LANE_W +: LANE_W];
    end
endmodule

// [rtl/sysbus_arbiter.sv]
// System bus arbiter and tenure controller with one internal master
//
// Summary of operation
// - As arbiter, drive address grant to external master.
// - As arbiter, drive data grant to external master.
// - Hold address busy low through own tenure.
// - After acknowledge, drive address busy high, release.
// - Never take address bus while others busy.
// - Hold data busy low through own tenure.
// - After transfer acknowledge, drive high, release.
// - Never take data bus while others busy.
// - Pulse transfer start opening each own address tenure.
// - Report external tenures, request snoop if enabled.
// - Address acknowledge ends the address tenure.
// - On retry, abandon and repeat the transaction.
// - Master drives write data, slave read data.
// - Data driver also drives lane parity.
// - Each lane plus parity holds odd ones.
// - Bus request output, or input as arbiter.
// - Grant line two serves request line two.
module sysbus_arbiter
    import sysbus_pkg::*;
(
    // Clock, enable and reset
    input wire logic clk,
    input wire logic clk_en,
    input wire logic reset_n,
    // Configuration levels
    input wire logic arbiter_mode,
    input wire logic snoop_en,
    // Internal master request, held until int_done
    input wire logic int_req,
    input wire logic int_write,
    input wire logic [sysbus_pkg::DATA_W-1:0] int_wdata,
    // Internal master answer
    output logic int_done,
    output logic int_retry,
    output logic [sysbus_pkg::DATA_W-1:0] int_rdata,
    output logic parity_err,
    // Events to the rest of the device
    output logic ext_tenure,
    output logic snoop_req,
    output logic dma_service_req,
    // Bus control pins
    input wire sysbus_pkg::pins_in_s pins_in,
    output sysbus_pkg::pins_out_s pins_out,
    output sysbus_pkg::pins_oe_s pins_oe,
    output logic address_bus_busy_out_n,
    output logic address_bus_busy_oe,
    output logic data_bus_busy_out_n,
    output logic data_bus_busy_oe,
    // Data and parity pins
    input wire logic [sysbus_pkg::DATA_W-1:0] data_in,
    input wire logic [sysbus_pkg::LANES-1:0] parity_in,
    output logic [sysbus_pkg::DATA_W-1:0] data_out,
    output logic [sysbus_pkg::LANES-1:0] parity_out,
    output logic data_oe
);
    import sysbus_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic [1:0] rst_pipe;       // Release pipeline
    logic rst_sync;             // Synchronised reset, active low

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////////////
    // State and helpers
    st_s st_reg;                        // Registered state
    st_s st_next;                       // Next state
    logic [LANES-1:0] wr_parity;        // Parity of outgoing data
    logic [LANES-1:0] rd_parity;        // Parity expected on incoming data
    logic abb_oe;                       // Our address busy enable
    logic dbb_oe;                       // Our data busy enable
    logic addr_busy_ext;                // Another master holds the address bus
    logic data_busy_ext;                // Another master holds the data bus
    logic start_ext;                    // Transfer start from another master
    logic addr_granted;                 // Address bus is ours to take
    logic data_granted;                 // Data bus is ours to take

    // Parity for writes and read checks
    lane_parity #(.DATA_W(DATA_W), .LANE_W(LANE_W)) u_wr_parity (
        .data(int_wdata),
        .parity(wr_parity)
    );
    lane_parity #(.DATA_W(DATA_W), .LANE_W(LANE_W)) u_rd_parity (
        .data(data_in),
        .parity(rd_parity)
    );

    // Our own drive looped back on a pin is not another master
    assign addr_busy_ext = !pins_in.address_bus_busy_n && !abb_oe;
    assign data_busy_ext = !pins_in.data_bus_busy_n && !dbb_oe;
    assign start_ext = !pins_in.transfer_start_n && !st_reg.pin_oe.transfer_start;
    // Grant source depends on who arbitrates
    assign addr_granted = arbiter_mode ? (st_reg.agrant == OWN_SELF)
                                       : !pins_in.addr_bus_grant_n;
    assign data_granted = arbiter_mode ? !st_reg.dgrant_ext1
                                       : !pins_in.data_bus_grant_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        // Pulses and start strobe default off
        st_next.done = 1'b0;
        st_next.retry = 1'b0;
        st_next.parity_err = 1'b0;
        st_next.pin_out.transfer_start_n = 1'b1;
        st_next.pin_oe.transfer_start = 1'b0;

        // Master sequencer
        case (st_reg.mst)
            M_IDLE: begin
                if (int_req) begin
                    st_next.mst = M_REQ;
                end
            end
            M_REQ: begin
                // Start only when granted and nobody else holds the bus
                if (addr_granted && !addr_busy_ext && !start_ext) begin
                    st_next.mst = M_ADDR;
                    st_next.pin_out.transfer_start_n = 1'b0;
                    st_next.pin_oe.transfer_start = 1'b1;
                end
            end
            M_ADDR: begin
                // Acknowledge closes the tenure, retry sends us back
                if (!pins_in.address_acknowledge_n) begin
                    if (!pins_in.address_retry_n) begin
                        st_next.mst = M_REQ;
                        st_next.retry = 1'b1;
                    end else begin
                        st_next.mst = M_WAIT_DATA;
                    end
                end
            end
            M_WAIT_DATA: begin
                // Data tenure opens when the data bus is free
                if (data_granted && !data_busy_ext) begin
                    st_next.mst = M_DATA;
                    st_next.data_oe = int_write;
                    st_next.data_out = int_wdata;
                    st_next.parity_out = wr_parity;
                end
            end
            M_DATA: begin
                // Transfer acknowledge ends the data tenure
                if (!pins_in.transfer_acknowledge_n) begin
                    st_next.mst = M_IDLE;
                    st_next.done = 1'b1;
                    st_next.data_oe = 1'b0;
                    if (!int_write) begin
                        st_next.rdata = data_in;
                        st_next.parity_err = (rd_parity != parity_in);
                    end
                end
            end
            default: begin
                st_next.mst = M_IDLE;
            end
        endcase

        // Arbiter, active only in arbiter mode
        if (arbiter_mode) begin
            // Acknowledge of an external tenure closes it, retried or not
            if (st_reg.tenure != OWN_NONE && !pins_in.address_acknowledge_n) begin
                st_next.tenure = OWN_NONE;
            end
            // Data grant drops once that master shows data busy
            if (st_reg.dgrant_ext1 && data_busy_ext) begin
                st_next.dgrant_ext1 = 1'b0;
            end
            // A new grant set wins over a clear in the same cycle
            if (st_reg.tenure == OWN_EXT1 && !pins_in.address_acknowledge_n
                    && pins_in.address_retry_n) begin
                st_next.dgrant_ext1 = 1'b1;
            end
            // Single grant holder keeps grants exclusive
            case (st_reg.agrant)
                OWN_NONE: begin
                    if (!addr_busy_ext && !start_ext && st_reg.mst != M_ADDR) begin
                        if (!pins_in.ext_bus_request_2_n) begin
                            st_next.agrant = OWN_EXT2;
                        end else if (!pins_in.bus_request_n) begin
                            st_next.agrant = OWN_EXT1;
                        end else if (st_reg.mst == M_REQ) begin
                            st_next.agrant = OWN_SELF;
                        end
                    end
                end
                OWN_SELF: begin
                    if (st_next.mst == M_ADDR) begin
                        st_next.agrant = OWN_NONE;
                    end
                end
                OWN_EXT1, OWN_EXT2: begin
                    // Grant is used up by the start, or withdrawn with the request
                    if (start_ext) begin
                        st_next.tenure = st_reg.agrant;
                        st_next.agrant = OWN_NONE;
                    end else if ((st_reg.agrant == OWN_EXT1 && pins_in.bus_request_n)
                            || (st_reg.agrant == OWN_EXT2 && pins_in.ext_bus_request_2_n)) begin
                        st_next.agrant = OWN_NONE;
                    end
                end
                default: begin
                    st_next.agrant = OWN_NONE;
                end
            endcase
        end else begin
            st_next.agrant = OWN_NONE;
            st_next.tenure = OWN_NONE;
            st_next.dgrant_ext1 = 1'b0;
        end

        // Grant and request pins follow the arbiter role
        st_next.pin_out.addr_bus_grant_n = !(st_next.agrant == OWN_EXT1);
        st_next.pin_out.ext_bus_grant_2_n = !(st_next.agrant == OWN_EXT2);
        st_next.pin_out.data_bus_grant_n = !st_next.dgrant_ext1;
        st_next.pin_out.bus_request_n = !(!arbiter_mode && st_next.mst == M_REQ);
        st_next.pin_oe.addr_bus_grant = arbiter_mode;
        st_next.pin_oe.data_bus_grant = arbiter_mode;
        st_next.pin_oe.bus_request = !arbiter_mode;

        // Slave side reaction to another master's tenure
        st_next.ext_tenure = start_ext;
        st_next.snoop_req = start_ext && snoop_en;
        st_next.dma_service_req = !pins_in.dma_request_line1_n;
    end

    // State register, reset clears every grant
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            st_reg <= ST_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Busy line drivers, low while owned
    busy_pin_drive u_addr_busy (
        .clk(clk),
        .rst_n(rst_sync),
        .clk_en(clk_en),
        .own(st_next.mst == M_ADDR),
        .pin_n(address_bus_busy_out_n),
        .pin_oe(abb_oe)
    );
    busy_pin_drive u_data_busy (
        .clk(clk),
        .rst_n(rst_sync),
        .clk_en(clk_en),
        .own(st_next.mst == M_DATA),
        .pin_n(data_bus_busy_out_n),
        .pin_oe(dbb_oe)
    );
    assign address_bus_busy_oe = abb_oe;
    assign data_bus_busy_oe = dbb_oe;

    // Outputs straight from state
    assign int_done = st_reg.done;
    assign int_retry = st_reg.retry;
    assign int_rdata = st_reg.rdata;
    assign parity_err = st_reg.parity_err;
    assign ext_tenure = st_reg.ext_tenure;
    assign snoop_req = st_reg.snoop_req;
    assign dma_service_req = st_reg.dma_service_req;
    assign pins_out = st_reg.pin_out;
    assign pins_oe = st_reg.pin_oe;
    assign data_out = st_reg.data_out;
    assign parity_out = st_reg.parity_out;
    assign data_oe = st_reg.data_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks, counted on enabled edges only
    default clocking cb @(posedge clk iff clk_en);
    endclocking
    default disable iff (!rst_sync);

    sequence s_addr_ack_ok;
        st_reg.mst == M_ADDR && !pins_in.address_acknowledge_n && pins_in.address_retry_n;
    endsequence
    sequence s_busy_release(logic lvl_n, logic oe);
        (oe && lvl_n) ##BUSY_RELEASE_CYCLES !oe;
    endsequence
    sequence s_data_ack;
        st_reg.mst == M_DATA && !pins_in.transfer_acknowledge_n;
    endsequence

    a_one_grant: assert property (!(!st_reg.pin_out.addr_bus_grant_n
            && !st_reg.pin_out.ext_bus_grant_2_n)) else $error("two address grants");
    a_grant_role: assert property (!arbiter_mode |-> ##1 (!pins_oe.addr_bus_grant
            && !pins_oe.data_bus_grant)) else $error("grant driven without arbiter role");
    a_start_pulse: assert property ($fell(pins_out.transfer_start_n) |=>
            pins_out.transfer_start_n && st_reg.mst == M_ADDR) else $error("start not one cycle");
    a_addr_busy_held: assert property (st_reg.mst == M_ADDR |->
            abb_oe && !address_bus_busy_out_n) else $error("address busy not held");
    a_addr_busy_release: assert property (s_addr_ack_ok |=>
            s_busy_release(address_bus_busy_out_n, abb_oe)) else $error("address busy release");
    a_addr_defer: assert property (st_reg.mst == M_REQ && addr_busy_ext |=>
            st_reg.mst == M_REQ) else $error("took busy address bus");
    a_data_busy_held: assert property (st_reg.mst == M_DATA |->
            dbb_oe && !data_bus_busy_out_n) else $error("data busy not held");
    a_data_busy_release: assert property (s_data_ack |=>
            s_busy_release(data_bus_busy_out_n, dbb_oe)) else $error("data busy release");
    a_data_defer: assert property (st_reg.mst == M_WAIT_DATA && data_busy_ext |=>
            st_reg.mst == M_WAIT_DATA) else $error("took busy data bus");
    a_retry_repeat: assert property (st_reg.mst == M_ADDR && !pins_in.address_acknowledge_n
            && !pins_in.address_retry_n |=> st_reg.mst == M_REQ && int_retry)
            else $error("retry not honoured");
    a_lane_odd: assert property (data_oe |-> (^{parity_out[0], data_out[LANE_W-1:0]}))
            else $error("lane zero parity even");
    a_snoop_tenure: assert property (start_ext && snoop_en |=> snoop_req && ext_tenure)
            else $error("external tenure not reported");
endmodule

// [rtl/sysbus_pkg.sv]
// Shared constants, pin carriers and state types for the system bus tenure arbiter
package sysbus_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int DATA_W = 32;                 // Data bus width
    localparam int LANE_W = 8;                  // Bits per parity lane
    localparam int LANES = DATA_W / LANE_W;     // One parity bit per lane

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: the busy lines are driven high for one cycle before release
    localparam int BUSY_RELEASE_CYCLES = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Master sequencer states
    typedef enum logic [2:0] {
        M_IDLE,         // No transaction pending
        M_REQ,          // Waiting for address bus ownership
        M_ADDR,         // Address tenure open
        M_WAIT_DATA,    // Waiting for data bus ownership
        M_DATA          // Data tenure open
    } mst_e;

    // Address bus grant holder
    typedef enum logic [1:0] {
        OWN_NONE,
        OWN_EXT1,       // Master on the shared request line
        OWN_EXT2,       // Master on external request line 2
        OWN_SELF        // Our own internal master
    } owner_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Sampled bus pins, all active low
    typedef struct packed {
        logic addr_bus_grant_n;
        logic data_bus_grant_n;
        logic address_bus_busy_n;
        logic data_bus_busy_n;
        logic transfer_start_n;
        logic address_acknowledge_n;
        logic address_retry_n;
        logic transfer_acknowledge_n;
        logic bus_request_n;
        logic ext_bus_request_2_n;
        logic dma_request_line1_n;
    } pins_in_s;

    // Driven pin levels, all active low
    typedef struct packed {
        logic addr_bus_grant_n;
        logic data_bus_grant_n;
        logic transfer_start_n;
        logic bus_request_n;
        logic ext_bus_grant_2_n;
    } pins_out_s;

    // Output enables of the two-way pins, high while we drive
    typedef struct packed {
        logic addr_bus_grant;
        logic data_bus_grant;
        logic transfer_start;
        logic bus_request;
    } pins_oe_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Top level state
    typedef struct packed {
        mst_e mst;                          // Master sequencer
        owner_e agrant;                     // Address grant holder
        owner_e tenure;                     // External address tenure in flight
        logic dgrant_ext1;                  // Data grant to external master 1
        pins_out_s pin_out;                 // Driven pin levels
        pins_oe_s pin_oe;                   // Pin enables
        logic [DATA_W-1:0] data_out;        // Write data on the bus
        logic data_oe;                      // Data and parity enable
        logic [LANES-1:0] parity_out;       // Lane parity on the bus
        logic done;                         // Transaction finished pulse
        logic retry;                        // Retry seen pulse
        logic [DATA_W-1:0] rdata;           // Captured read data
        logic parity_err;                   // Read parity error pulse
        logic ext_tenure;                   // External tenure pulse
        logic snoop_req;                    // Snoop request pulse
        logic dma_service_req;              // Registered DMA request
    } st_s;

    localparam pins_out_s PINS_IDLE = '{default: 1'b1};
    localparam st_s ST_RESET = '{mst: M_IDLE, agrant: OWN_NONE, tenure: OWN_NONE,
        pin_out: PINS_IDLE, default: '0};

    // Busy pin driver state
    typedef struct packed {
        logic own_q;        // Ownership last cycle
        logic pin_n;        // Driven level
        logic oe;           // Driving
    } busy_s;

    localparam busy_s BUSY_RESET = '{own_q: 1'b0, pin_n: 1'b1, oe: 1'b0};

endpackage

// [verif/far_side.sv]
// Far side of the bus: outside arbiter, slave, pull-ups and wired-AND resolution
module far_side
    import sysbus_pkg::*;
(
    // Clock and scenario controls
    input wire logic clk,
    input wire logic serve,
    input wire logic slow,
    input wire logic retry_once,
    input wire logic bad_par,
    input wire logic [31:0] rd_word,
    input wire sysbus_pkg::pins_in_s tb_n,
    // Device side pins
    input wire sysbus_pkg::pins_out_s po,
    input wire sysbus_pkg::pins_oe_s oe,
    input wire logic abusy_n,
    input wire logic abusy_oe,
    input wire logic dbusy_n,
    input wire logic dbusy_oe,
    input wire logic [31:0] dq_out,
    input wire logic [3:0] par_out,
    input wire logic dq_oe,
    // Resolved wires
    output sysbus_pkg::pins_in_s pins_in,
    output logic [31:0] data_in,
    output logic [3:0] parity_in
);
    logic gnt_n = 1'b1, ack_n = 1'b1, rty_n = 1'b1, xack_n = 1'b1, d_seen = 1'b0;
    logic retried = 1'b0; // One retry per armed scenario
    logic [1:0] a_wait = 2'b00; // Shift timer up to the address acknowledge
    logic start_ours, dbusy_ours;
    assign start_ours = oe.transfer_start & ~po.transfer_start_n;
    assign dbusy_ours = dbusy_oe & ~dbusy_n;
    // Grant on request; slow mode delays both acknowledges one cycle
    always_ff @(posedge clk) begin
        gnt_n <= ~(serve & oe.bus_request & ~po.bus_request_n);
        a_wait <= start_ours ? {slow, ~slow} : a_wait >> 1;
        ack_n <= ~a_wait[0];
        rty_n <= ~(a_wait[0] & retry_once & ~retried);
        retried <= retry_once & (retried | a_wait[0]);
        d_seen <= dbusy_ours;
        xack_n <= ~(dbusy_ours & xack_n & (d_seen | ~slow));
    end
    // Pull-up on every line, low wins; released data shows the inverse pattern
    always_comb begin
        pins_in = tb_n;
        pins_in.addr_bus_grant_n &= gnt_n & (po.addr_bus_grant_n | ~oe.addr_bus_grant);
        pins_in.data_bus_grant_n &= ~serve | oe.data_bus_grant;
        pins_in.data_bus_grant_n &= po.data_bus_grant_n | ~oe.data_bus_grant;
        pins_in.transfer_start_n &= po.transfer_start_n | ~oe.transfer_start;
        pins_in.bus_request_n &= po.bus_request_n | ~oe.bus_request;
        pins_in.address_bus_busy_n &= abusy_n | ~abusy_oe;
        pins_in.data_bus_busy_n &= dbusy_n | ~dbusy_oe;
        pins_in.address_acknowledge_n &= ack_n;
        pins_in.address_retry_n &= rty_n;
        pins_in.transfer_acknowledge_n &= xack_n;
        data_in = dq_oe ? dq_out : (dbusy_ours ? rd_word : ~rd_word);
        for (int k = 0; k < 4; k++) parity_in[k] = ~^data_in[8*k+:8];
        parity_in[0] ^= bad_par;
        if (dq_oe) begin
            parity_in = par_out;
        end
    end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the bus arbiter against the far-side model
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sysbus_pkg::*;
    logic clk = 0, reset_n = 0, arbiter_mode = 0, snoop_en = 1, int_req = 0, int_write = 0;
    logic slow = 0, retry_once = 0, bad_par = 0, int_done, int_retry, parity_err, data_oe;
    logic ext_tenure, snoop_req, dma_service_req, address_bus_busy_out_n, address_bus_busy_oe;
    logic data_bus_busy_out_n, data_bus_busy_oe;
    logic [31:0] int_wdata = 0, rd_word = 0, int_rdata, data_in, data_out, wexp = 0;
    logic [3:0] parity_in, parity_out;
    logic [35:0] e; // Note: retries, read, parity error, read data
    logic [35:0] exp_q[$];
    pins_in_s tb_n = '1, pins_in;
    pins_out_s pins_out;
    pins_oe_s pins_oe;
    int miscompares = 0, tests_run = 0, seed = 58191, rty = 0, ts_cnt = 0, i;
    always #20 clk = ~clk;
    sysbus_arbiter sysbus_arbiter_i (.clk, .clk_en(1'b1), .reset_n, .arbiter_mode, .snoop_en,
        .int_req, .int_write, .int_wdata, .int_done, .int_retry, .int_rdata, .parity_err,
        .ext_tenure, .snoop_req, .dma_service_req, .pins_in, .pins_out, .pins_oe,
        .address_bus_busy_out_n, .address_bus_busy_oe, .data_bus_busy_out_n,
        .data_bus_busy_oe, .data_in, .parity_in, .data_out, .parity_out, .data_oe);
    far_side far_side_i (.clk, .serve(~arbiter_mode), .slow, .retry_once, .bad_par, .rd_word,
        .tb_n, .po(pins_out), .oe(pins_oe), .abusy_n(address_bus_busy_out_n),
        .abusy_oe(address_bus_busy_oe), .dbusy_n(data_bus_busy_out_n),
        .dbusy_oe(data_bus_busy_oe), .dq_out(data_out), .par_out(parity_out),
        .dq_oe(data_oe), .pins_in, .data_in, .parity_in);
    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatched %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One internal transfer; request held until the data acknowledge is on the wire
    task automatic tx(input logic wr, input logic [1:0] rtry, input logic perr);
        int n;
        wexp = $random(seed);
        rd_word <= ~wexp;
        exp_q.push_back({rtry, ~wr, perr, ~wexp});
        int_write <= wr;
        int_wdata <= wexp;
        int_req <= 1'b1;
        for (n = 0; n < 60 && pins_in.transfer_acknowledge_n !== 1'b0; n++) @(posedge clk);
        int_req <= 1'b0;
        if (n == 60) begin
            miscompares++;
            $display("BAD %0t no data acknowledge", $time);
            close_out();
        end
        repeat (3) @(posedge clk);
    endtask
    // Another master opens a tenure, the slave acknowledges it next cycle
    task automatic foreign_start();
        tb_n.transfer_start_n <= 1'b0;
        @(posedge clk);
        tb_n.transfer_start_n <= 1'b1;
        tb_n.address_acknowledge_n <= 1'b0;
        @(posedge clk);
        tb_n.address_acknowledge_n <= 1'b1;
    endtask
    // Watcher: bus checks each cycle, oldest note compared on every done
    always @(posedge clk) begin
        if (int_retry === 1'b1) rty++;
        if (pins_oe.transfer_start === 1'b1 && pins_out.transfer_start_n === 1'b0) begin
            ts_cnt++;
            chk({address_bus_busy_oe, address_bus_busy_out_n}, 2'b10);
        end
        if (data_oe === 1'b1) begin
            chk({data_bus_busy_oe, data_bus_busy_out_n, data_out}, {2'b10, wexp});
            for (int k = 0; k < 4; k++) chk(^{parity_out[k], data_out[8*k+:8]}, 1);
        end
        if (int_done === 1'b1) begin
            e = exp_q.pop_front();
            chk({rty[1:0], e[33] ? int_rdata : e[31:0]}, {e[35:34], e[31:0]});
            chk({parity_err, data_bus_busy_oe, data_bus_busy_out_n}, {e[32], 2'b11});
            rty = 0;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({pins_out, pins_oe, data_oe}, {5'h1F, 5'h02});
        tx(1'b1, 2'd0, 1'b0);
        tx(1'b0, 2'd0, 1'b0);
        slow <= 1'b1;
        bad_par <= 1'b1;
        tx(1'b0, 2'd0, 1'b1);
        bad_par <= 1'b0;
        retry_once <= 1'b1;
        tx(1'b1, 2'd1, 1'b0);
        retry_once <= 1'b0;
        tb_n.address_bus_busy_n <= 1'b0;
        i = ts_cnt;
        fork
            tx(1'b1, 2'd0, 1'b0);
            begin
                repeat (8) @(posedge clk);
                chk(ts_cnt, i);
                tb_n.address_bus_busy_n <= 1'b1;
            end
        join
        arbiter_mode <= 1'b1;
        tb_n.ext_bus_request_2_n <= 1'b0;
        tb_n.bus_request_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk({pins_out.ext_bus_grant_2_n, pins_oe.addr_bus_grant && !pins_out.addr_bus_grant_n},
            2'b00);
        tb_n.ext_bus_request_2_n <= 1'b1;
        foreign_start();
        chk({ext_tenure, snoop_req}, 2'b11);
        repeat (2) @(posedge clk);
        chk({pins_out.ext_bus_grant_2_n, pins_oe.addr_bus_grant && !pins_out.addr_bus_grant_n},
            2'b11);
        tb_n.bus_request_n <= 1'b1;
        foreign_start();
        repeat (2) @(posedge clk);
        chk(pins_oe.data_bus_grant && !pins_out.data_bus_grant_n, 1);
        tb_n.dma_request_line1_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(dma_service_req, 1);
        // Master one opens its data tenure, then our master is self-granted
        tb_n.data_bus_busy_n <= 1'b0;
        @(posedge clk);
        tb_n.data_bus_busy_n <= 1'b1;
        tx(1'b1, 2'd0, 1'b0);
        close_out();
    end
endmodule
